// ---- hw/servo_torque_limit_select.sv ----
// torque limit table, analog limit path, clamp and status with axi4-lite registers
module servo_torque_limit_select #(
  parameter int unsigned GAIN_W = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic torque_limit_enable_in, // high: limit active
  input wire logic data_select_bit0, // entry select, lsb
  input wire logic data_select_bit1,
  input wire logic data_select_bit2, // entry select, msb
  input wire logic signed [15:0] analog_mv_in, // analog command, signed millivolts
  input wire logic [9:0] torque_demand_in, // loop torque request, percent
  input wire logic servo_on_in, // excitation request in servo lock mode
  output logic [9:0] torque_cmd_out, // torque after clamp, percent
  output logic [9:0] active_limit_out, // limit in force, percent
  output logic [2:0] entry_sel_out, // entry shared with speed and accel tables
  output logic torque_limiting_status_out, // limit reached
  output logic motor_energized_out, // motor excited
  output logic hold_position_out, // command position still refreshed
  output logic irq
);
  localparam int unsigned E = torque_limit_pkg::ENTRIES;

  // configuration and table storage
  logic ana_req_r = 1'b1; // requested analog enable, power-on value enabled, kept through reset
  logic ana_live_r; // analog enable in force
  logic auto_r; // automatic offset enable
  logic free_mode_r; // after-stop mode, 1 = free
  logic [GAIN_W-1:0] gain_r; // percent per volt
  logic signed [15:0] offs_r; // offset voltage, millivolts
  logic [9:0] table_r [E]; // digital limit entries
  logic [torque_limit_pkg::IRQ_W-1:0] ev_r; // sticky events
  logic [torque_limit_pkg::IRQ_W-1:0] mask_r; // interrupt mask
  logic strap_done_r; // first cycle after reset release seen

  // axi handshake state
  logic aw_held_r, w_held_r; // address or data taken, waiting for the other
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // write channel: take address and data in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_r || aw_take;
  wire w_have = w_held_r || w_take;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire aw_held_nxt = aw_have && !do_write; // address waits for its data
  wire w_held_nxt = w_have && !do_write; // data waits for its address
  wire bvalid_nxt = do_write || (s_axi_bvalid && !s_axi_bready); // response stands until taken
  wire [7:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_held_r ? wstrb_r : s_axi_wstrb;
  wire ws_lo = ws[0]; // low byte lane
  wire ws_hi = ws[1]; // second byte lane

  // decode used by both read and write paths
  function automatic logic in_table(input logic [7:0] a);
    return a[7:5] == torque_limit_pkg::OFF_TABLE[7:5] && a[1:0] == 2'h0;
  endfunction
  function automatic logic mapped(input logic [7:0] a);
    return in_table(a) || a == torque_limit_pkg::OFF_CTRL || a == torque_limit_pkg::OFF_GAIN
      || a == torque_limit_pkg::OFF_OFFS || a == torque_limit_pkg::OFF_CMD
      || a == torque_limit_pkg::OFF_STAT || a == torque_limit_pkg::OFF_IRQ
      || a == torque_limit_pkg::OFF_MASK;
  endfunction

  wire wr_ctrl = do_write && wa == torque_limit_pkg::OFF_CTRL && ws_lo;
  wire wr_gain = do_write && wa == torque_limit_pkg::OFF_GAIN;
  wire wr_offs = do_write && wa == torque_limit_pkg::OFF_OFFS;
  wire wr_irq = do_write && wa == torque_limit_pkg::OFF_IRQ && ws_lo;
  wire wr_mask = do_write && wa == torque_limit_pkg::OFF_MASK && ws_lo;
  wire wr_tab = do_write && in_table(wa);
  wire [2:0] tab_idx = wa[4:2];
  // capture only while automatic offset is enabled
  wire capture = do_write && wa == torque_limit_pkg::OFF_CMD && ws_lo && wd[0] && auto_r;

  // merged 10-bit field write with byte lanes
  wire [9:0] gain_wr = {ws_hi ? wd[9:8] : 2'(gain_r[9:8]), ws_lo ? wd[7:0] : 8'(gain_r[7:0])};
  wire [9:0] tab_old = table_r[tab_idx];
  wire [9:0] tab_wr = {ws_hi ? wd[9:8] : tab_old[9:8], ws_lo ? wd[7:0] : tab_old[7:0]};
  // values above 300 percent are saturated, keeping entries in range
  wire [9:0] tab_sat = (tab_wr > torque_limit_pkg::PCT_MAX) ? torque_limit_pkg::PCT_MAX : tab_wr;
  wire [9:0] gain_sat = (gain_wr > torque_limit_pkg::PCT_MAX) ? torque_limit_pkg::PCT_MAX : gain_wr;
  wire [15:0] offs_wr = {ws_hi ? wd[15:8] : offs_r[15:8], ws_lo ? wd[7:0] : offs_r[7:0]};

  // axi write handshake; bresp is slverr for unmapped addresses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= torque_limit_pkg::RESP_OKAY;
      s_axi_awready <= 1'b1; // ready while in reset
      s_axi_wready <= 1'b1;
    end else begin
      if (aw_take) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (do_write) begin
        s_axi_bresp <= mapped(wa) ? torque_limit_pkg::RESP_OKAY : torque_limit_pkg::RESP_SLVERR;
      end
      // ready only while that channel is empty and no response is pending; built from
      // next-state terms so the ports come straight from flip-flops
      s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
      s_axi_wready <= !w_held_nxt && !bvalid_nxt;
    end
  end

  // configuration registers; analog enable is latched once after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_live_r <= 1'b1;
      strap_done_r <= 1'b0;
      auto_r <= 1'b0;
      free_mode_r <= 1'b0;
      gain_r <= GAIN_W'(torque_limit_pkg::GAIN_RST);
      offs_r <= 16'h0000;
      mask_r <= '0;
    end else begin
      strap_done_r <= 1'b1;
      // the requested value reaches the live copy only across a reset
      if (!strap_done_r) begin
        ana_live_r <= ana_req_r;
      end
      if (wr_ctrl) begin
        auto_r <= wd[torque_limit_pkg::CTRL_AUTO];
        free_mode_r <= wd[torque_limit_pkg::CTRL_FREE];
      end
      if (wr_gain) begin
        gain_r <= GAIN_W'(gain_sat);
      end
      if (capture) begin
        offs_r <= analog_mv_in;
      end else if (wr_offs) begin
        offs_r <= offs_wr;
      end
      if (wr_mask) begin
        mask_r <= wd[torque_limit_pkg::IRQ_W-1:0];
      end
    end
  end

  // analog enable request has no reset, so a request survives the reset that stands in for
  // a power cycle; the live copy only picks it up after that reset
  always_ff @(posedge aclk) begin
    if (aresetn && wr_ctrl) begin
      ana_req_r <= wd[torque_limit_pkg::CTRL_ANA];
    end
  end

  // limit table, one word per entry
  generate
    for (genvar i = 0; i < E; i++) begin : g_tab
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          table_r[i] <= torque_limit_pkg::LIMIT_RST;
        end else if (wr_tab && tab_idx == 3'(i)) begin
          table_r[i] <= tab_sat;
        end
      end
    end
  endgenerate

  // analog limit: gain times (volts minus offset), saturated
  wire signed [16:0] diff_mv = 17'(analog_mv_in) - 17'(offs_r);
  wire [15:0] diff_pos = diff_mv[16] ? 16'h0000 : (diff_mv[15] ? 16'h7FFF : diff_mv[15:0]);
  wire [31:0] prod = 32'(diff_pos) * 32'(gain_r);
  wire [31:0] ana_pct = prod / 32'(torque_limit_pkg::MV_PER_V);
  wire [9:0] ana_lim = (ana_pct > 32'(torque_limit_pkg::PCT_MAX)) ?
    torque_limit_pkg::PCT_MAX : ana_pct[9:0];

  // selection: one entry number for every parameter
  wire [2:0] entry = {data_select_bit2, data_select_bit1, data_select_bit0};
  wire use_ana = ana_live_r && entry[2:1] == 2'h0;
  torque_limit_pkg::sel_type sel;
  assign sel.entry = entry;
  assign sel.limit = use_ana ? ana_lim : table_r[entry];

  // clamp stage
  wire [9:0] lim_now = torque_limit_enable_in ? sel.limit : torque_limit_pkg::PCT_MAX;
  wire zero_hold = free_mode_r && torque_limit_enable_in && sel.limit == 10'h000;
  wire [9:0] cmd_nxt = (torque_demand_in > lim_now) ? lim_now : torque_demand_in;
  wire reach_nxt = torque_limit_enable_in && torque_demand_in >= sel.limit;
  wire energ_nxt = free_mode_r ? !zero_hold : servo_on_in;
  logic reach_r;

  // registered outputs; release of the enable drops the clamp next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      torque_cmd_out <= 10'h000;
      active_limit_out <= torque_limit_pkg::PCT_MAX;
      entry_sel_out <= 3'h0;
      reach_r <= 1'b0;
      motor_energized_out <= 1'b0;
      hold_position_out <= 1'b0;
    end else begin
      torque_cmd_out <= cmd_nxt;
      active_limit_out <= lim_now;
      entry_sel_out <= sel.entry;
      reach_r <= reach_nxt;
      motor_energized_out <= energ_nxt;
      hold_position_out <= 1'b1;
    end
  end
  assign torque_limiting_status_out = reach_r;

  // events, set wins over write-one-clear
  wire [torque_limit_pkg::IRQ_W-1:0] ev_set = {capture, reach_nxt && !reach_r};
  wire [torque_limit_pkg::IRQ_W-1:0] ev_clr = wr_irq ? wd[torque_limit_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_r <= '0;
      irq <= 1'b0;
    end else begin
      ev_r <= (ev_r & ~ev_clr) | ev_set;
      irq <= |(((ev_r & ~ev_clr) | ev_set) & mask_r);
    end
  end

  // read path, one cycle after acceptance
  wire [31:0] stat_word = {16'h0000, ana_live_r, torque_limiting_status_out,
    entry_sel_out, 1'b0, active_limit_out};
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_nxt =
    in_table(ra) ? {22'h0, table_r[ra[4:2]]} :
    ra == torque_limit_pkg::OFF_CTRL ? {29'h0, free_mode_r, auto_r, ana_req_r} :
    ra == torque_limit_pkg::OFF_GAIN ? 32'(gain_r) :
    ra == torque_limit_pkg::OFF_OFFS ? {16'h0000, offs_r} :
    ra == torque_limit_pkg::OFF_STAT ? stat_word :
    ra == torque_limit_pkg::OFF_IRQ ? 32'(ev_r) :
    ra == torque_limit_pkg::OFF_MASK ? 32'(mask_r) : 32'h0000_0000;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rvalid_nxt = ar_take || (s_axi_rvalid && !s_axi_rready); // data stands until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= torque_limit_pkg::RESP_OKAY;
      s_axi_arready <= 1'b1; // ready while in reset
    end else begin
      s_axi_rvalid <= rvalid_nxt;
      s_axi_arready <= !rvalid_nxt; // one read outstanding at most
      if (ar_take) begin
        s_axi_rdata <= rd_nxt;
        s_axi_rresp <= mapped(ra) ? torque_limit_pkg::RESP_OKAY : torque_limit_pkg::RESP_SLVERR;
      end
    end
  end

  // checks
  property p_clamp;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && torque_limit_enable_in |=> torque_cmd_out <= $past(sel.limit);
  endproperty
  a_clamp: assert property (p_clamp) else $error("torque above selected limit");
  property p_full;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && !torque_limit_enable_in |=> active_limit_out == torque_limit_pkg::PCT_MAX;
  endproperty
  a_full: assert property (p_full) else $error("limit not 300 while disabled");
  property p_entry;
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> entry_sel_out == $past({data_select_bit2, data_select_bit1, data_select_bit0});
  endproperty
  a_entry: assert property (p_entry) else $error("entry number wrong");
  property p_live;
    @(posedge aclk) disable iff (!aresetn)
    strap_done_r |=> $stable(ana_live_r);
  endproperty
  a_live: assert property (p_live) else $error("analog enable changed in operation");
  property p_sat;
    @(posedge aclk) disable iff (!aresetn)
    ana_lim <= 10'h12C;
  endproperty
  a_sat: assert property (p_sat) else $error("analog limit above 300");
  property p_tlc;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && torque_limit_enable_in && torque_demand_in >= sel.limit
      |=> torque_limiting_status_out;
  endproperty
  a_tlc: assert property (p_tlc) else $error("status missing at limit");
  sequence s_cap;
    capture ##1 1'b1;
  endsequence
  property p_cap;
    @(posedge aclk) disable iff (!aresetn)
    s_cap |-> offs_r == $past(analog_mv_in) && ev_r[1];
  endproperty
  a_cap: assert property (p_cap) else $error("offset not captured");
  property p_free0;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && zero_hold |=> !motor_energized_out && torque_cmd_out == 10'h000;
  endproperty
  a_free0: assert property (p_free0) else $error("torque in free zero limit");
  property p_tlc_off;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && !(torque_limit_enable_in && torque_demand_in >= sel.limit)
      |=> !torque_limiting_status_out;
  endproperty
  a_tlc_off: assert property (p_tlc_off) else $error("status set early");
  property p_release;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && !torque_limit_enable_in |=> torque_cmd_out == (($past(torque_demand_in)
      > torque_limit_pkg::PCT_MAX) ? torque_limit_pkg::PCT_MAX : $past(torque_demand_in));
  endproperty
  a_release: assert property (p_release) else $error("torque not at demand");
  property p_lock;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && !free_mode_r |=> motor_energized_out == $past(servo_on_in);
  endproperty
  a_lock: assert property (p_lock) else $error("excitation not following servo on");
  property p_digital;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && !ana_live_r |-> sel.limit == table_r[entry];
  endproperty
  a_digital: assert property (p_digital) else $error("analog used while disabled");
  property p_ana_zero;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && analog_mv_in <= offs_r |-> ana_lim == 10'h000;
  endproperty
  a_ana_zero: assert property (p_ana_zero) else $error("limit above zero at offset");
  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    aresetn |=> irq == |(ev_r & $past(mask_r));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  // bus checks: refusal while an answer stands, and the write answer after both halves
  property p_wbusy;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wbusy: assert property (p_wbusy) else $error("write accepted while response pending");
  property p_rbusy;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rbusy: assert property (p_rbusy) else $error("read accepted while data pending");
  sequence s_wr_both;
    aresetn && do_write;
  endsequence
  sequence s_b_answer;
    s_axi_bvalid ##1 (s_axi_bvalid != $past(s_axi_bready));
  endsequence
  property p_wresp;
    @(posedge aclk) disable iff (!aresetn)
    s_wr_both |=> s_b_answer;
  endproperty
  a_wresp: assert property (p_wresp) else $error("write response not given or not held");
endmodule // servo_torque_limit_select

// ---- hw/torque_limit_pkg.sv ----
// constants, register map and carrier types for the torque limit selector
package torque_limit_pkg;
  localparam int unsigned DATA_W = 32; // bus data width
  localparam int unsigned PCT_W = 10; // percent field width, holds 0..1023
  localparam logic [9:0] PCT_MAX = 10'h12C; // full torque, 300 percent
  localparam logic [9:0] GAIN_RST = 10'h01E; // gain after reset, 30 percent per volt
  localparam logic [9:0] LIMIT_RST = 10'h12C; // table entries after reset
  localparam int unsigned ENTRIES = 8; // operation data entries
  localparam int unsigned MV_W = 16; // signed millivolt sample width
  localparam int MV_PER_V = 1000; // millivolts in one volt
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00; // bit0 analog enable, bit1 auto offset
  localparam logic [7:0] OFF_GAIN = 8'h04; // analog gain, percent per volt
  localparam logic [7:0] OFF_OFFS = 8'h08; // offset voltage, signed millivolts
  localparam logic [7:0] OFF_CMD = 8'h0C; // write bit0: capture offset
  localparam logic [7:0] OFF_STAT = 8'h10; // read: live state
  localparam logic [7:0] OFF_IRQ = 8'h14; // sticky events, write one to clear
  localparam logic [7:0] OFF_MASK = 8'h18; // interrupt mask
  localparam logic [7:0] OFF_TABLE = 8'h20; // eight limit words from here
  // field positions
  localparam int unsigned CTRL_ANA = 0; // analog enable request
  localparam int unsigned CTRL_AUTO = 1; // automatic offset enable
  localparam int unsigned CTRL_FREE = 2; // after-stop mode, 1 = free
  localparam int unsigned IRQ_W = 2; // event count
  localparam int unsigned EV_TLC_RISE = 0; // limit reached
  localparam int unsigned EV_CAPTURE = 1; // offset captured
  localparam logic [1:0] RESP_OKAY = 2'h0; // axi okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // axi slave error
  // selection result handed between the select and clamp stages
  typedef struct packed {
    logic [2:0] entry; // selected entry number
    logic [9:0] limit; // selected limit in percent
  } sel_type;
endpackage : torque_limit_pkg

// ---- verification/controller_model.sv ----
// behavioural outside controller driving limit enable, entry select and analog levels
module controller_model (
  input wire logic aclk,
  output logic torque_limit_enable_in,
  output logic data_select_bit0,
  output logic data_select_bit1,
  output logic data_select_bit2,
  output logic signed [15:0] analog_mv_in,
  output logic [9:0] torque_demand_in,
  output logic servo_on_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero: limit off, entry 0, zero volts
  initial begin
    torque_limit_enable_in = 1'b0;
    {data_select_bit2, data_select_bit1, data_select_bit0} = 3'h0;
    analog_mv_in = 16'sh0000;
    torque_demand_in = 10'h000;
    servo_on_in = 1'b0;
  end
  // every level moves on one edge, so no half-changed entry number is ever seen
  task automatic apply(input logic en, input logic [2:0] entry,
      input logic signed [15:0] mv, input logic [9:0] dem, input logic son);
    @(posedge aclk);
    torque_limit_enable_in <= en;
    data_select_bit2 <= entry[2];
    data_select_bit1 <= entry[1];
    data_select_bit0 <= entry[0];
    analog_mv_in <= mv;
    torque_demand_in <= dem;
    servo_on_in <= son;
  endtask
endmodule // controller_model

// ---- verification/tb_top.sv ----
// self-checking bench: axi4-lite register access and limit path scenarios
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0; // 125 MHz
  logic aresetn = 1'b0; // sync, active low
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF; // whole words only
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic torque_limit_enable_in, data_select_bit0, data_select_bit1, data_select_bit2;
  logic signed [15:0] analog_mv_in;
  logic [9:0] torque_demand_in, torque_cmd_out, active_limit_out;
  logic servo_on_in, torque_limiting_status_out, motor_energized_out, hold_position_out, irq;
  logic [2:0] entry_sel_out;
  int err_total = 0; // mismatches
  int tests_run = 0; // comparisons
  // table words written and the values expected back (writes above 300 saturate)
  logic [31:0] tw [8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h96, 32'h12B, 32'h12C, 32'h12D};
  logic [9:0] te [8] = '{10'h0, 10'h0, 10'h0, 10'h1, 10'h96, 10'h12B, 10'h12C, 10'h12C};
  logic [31:0] d;
  logic [1:0] r;
  always #4 aclk = ~aclk;
  servo_torque_limit_select dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .torque_limit_enable_in,
    .data_select_bit0, .data_select_bit1, .data_select_bit2, .analog_mv_in,
    .torque_demand_in, .servo_on_in, .torque_cmd_out, .active_limit_out, .entry_sel_out,
    .torque_limiting_status_out, .motor_energized_out, .hold_position_out, .irq);
  controller_model ctl (.aclk, .torque_limit_enable_in, .data_select_bit0,
    .data_select_bit1, .data_select_bit2, .analog_mv_in, .torque_demand_in, .servo_on_in);
  // single write; address and data released separately as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok;
    @(posedge aclk);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", torque_limit_pkg::RESP_OKAY, s_axi_bresp)
  endtask
  // single read; rready held until the answer is sampled
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // read and compare the masked field
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex,
      input string nm);
    logic [31:0] v;
    logic [1:0] rr;
    rd(a, v, rr);
    `CHK(nm, ex & m, v & m)
    `CHK("rresp", torque_limit_pkg::RESP_OKAY, rr)
  endtask
  // apply levels, let the one-cycle datapath settle, compare clamp, limit, status, entry
  task automatic chk_path(input logic en, input logic [2:0] e, input logic signed [15:0] mv,
      input logic [9:0] dem, input logic [9:0] sel, input logic son);
    logic [9:0] lim;
    lim = en ? sel : torque_limit_pkg::PCT_MAX;
    ctl.apply(en, e, mv, dem, son);
    repeat (3) @(posedge aclk);
    `CHK("active_limit", lim, active_limit_out)
    `CHK("torque_cmd", (dem < lim) ? dem : lim, torque_cmd_out)
    `CHK("limit_status", en && (dem >= sel), torque_limiting_status_out)
    `CHK("entry_sel", e, entry_sel_out)
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (30000) @(posedge aclk);
    err_total++;
    $display("Error watchdog expired");
    report_and_stop;
  end
  // main sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(torque_limit_pkg::OFF_CTRL, 32'h7, 32'h1, "ctrl_reset");
    rdc(torque_limit_pkg::OFF_STAT, 32'h8000, 32'h8000, "analog_live");
    rdc(torque_limit_pkg::OFF_GAIN, 32'h3FF, 32'h1E, "gain_reset");
    for (int n = 0; n < 8; n++) rdc(8'(32 + 4 * n), 32'h3FF, 32'h12C, "table_reset");
    rd(8'hFC, d, r);
    `CHK("unmapped_resp", torque_limit_pkg::RESP_SLVERR, r)
    `CHK("unmapped_data", 32'h0, d)
    for (int n = 2; n < 8; n++) begin
      wr(8'(32 + 4 * n), tw[n]);
      rdc(8'(32 + 4 * n), 32'h3FF, {22'h0, te[n]}, "table");
      chk_path(1'b1, 3'(n), 16'sh0000, 10'h12C, te[n], 1'b1);
      chk_path(1'b1, 3'(n), 16'sh0000, 10'h064, te[n], 1'b1);
      chk_path(1'b0, 3'(n), 16'sh0000, 10'h12C, te[n], 1'b1);
    end
    // interrupt: raised by earlier status rises, masked, unmasked, cleared
    rdc(torque_limit_pkg::OFF_IRQ, 32'h1, 32'h1, "irq_sticky");
    `CHK("irq_masked", 1'b0, irq)
    wr(torque_limit_pkg::OFF_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("irq_unmasked", 1'b1, irq)
    wr(torque_limit_pkg::OFF_IRQ, 32'h1);
    repeat (2) @(posedge aclk);
    `CHK("irq_cleared", 1'b0, irq)
    // analog entries 0 and 1
    chk_path(1'b1, 3'h0, 16'sh1388, 10'h12C, 10'h096, 1'b1);
    chk_path(1'b1, 3'h1, 16'shF830, 10'h032, 10'h000, 1'b1);
    wr(torque_limit_pkg::OFF_GAIN, 32'h190);
    rdc(torque_limit_pkg::OFF_GAIN, 32'h3FF, 32'h12C, "gain_sat");
    chk_path(1'b1, 3'h0, 16'sh07D0, 10'h12C, 10'h12C, 1'b1);
    wr(torque_limit_pkg::OFF_GAIN, 32'h1E);
    wr(torque_limit_pkg::OFF_OFFS, 32'h3E8);
    chk_path(1'b1, 3'h1, 16'sh1388, 10'h12C, 10'h078, 1'b1);
    // analog enable cleared in operation must not take effect before a power cycle
    wr(torque_limit_pkg::OFF_CTRL, 32'h0);
    rdc(torque_limit_pkg::OFF_STAT, 32'h8000, 32'h8000, "analog_live");
    chk_path(1'b1, 3'h0, 16'sh1388, 10'h12C, 10'h078, 1'b1);
    // automatic offset capture with the input held at zero volts
    wr(torque_limit_pkg::OFF_CTRL, 32'h3);
    ctl.apply(1'b1, 3'h0, 16'sh0000, 10'h064, 1'b1);
    wr(torque_limit_pkg::OFF_CMD, 32'h1);
    rdc(torque_limit_pkg::OFF_OFFS, 32'hFFFF, 32'h0, "offset_capture");
    rdc(torque_limit_pkg::OFF_IRQ, 32'h2, 32'h2, "capture_event");
    chk_path(1'b1, 3'h0, 16'sh1388, 10'h12C, 10'h096, 1'b1);
    // free after stop with a zero limit, then release; then servo lock
    wr(torque_limit_pkg::OFF_CTRL, 32'h5);
    chk_path(1'b1, 3'h2, 16'sh0000, 10'h064, 10'h000, 1'b1);
    `CHK("energized_free", 1'b0, motor_energized_out)
    `CHK("hold_position", 1'b1, hold_position_out)
    chk_path(1'b0, 3'h2, 16'sh0000, 10'h064, 10'h000, 1'b1);
    `CHK("energized_release", 1'b1, motor_energized_out)
    wr(torque_limit_pkg::OFF_CTRL, 32'h1);
    chk_path(1'b1, 3'h2, 16'sh0000, 10'h064, 10'h000, 1'b0);
    `CHK("energized_lock_off", 1'b0, motor_energized_out)
    chk_path(1'b1, 3'h2, 16'sh0000, 10'h064, 10'h000, 1'b1);
    `CHK("energized_lock_on", 1'b1, motor_energized_out)
    // analog enable cleared, then a reset standing in for a power cycle makes it count
    wr(torque_limit_pkg::OFF_CTRL, 32'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(torque_limit_pkg::OFF_CTRL, 32'h7, 32'h0, "ctrl_kept");
    rdc(torque_limit_pkg::OFF_STAT, 32'h8000, 32'h0, "analog_off");
    wr(torque_limit_pkg::OFF_TABLE, 32'h50);
    chk_path(1'b1, 3'h0, 16'sh1388, 10'h12C, 10'h050, 1'b1);
    chk_path(1'b1, 3'h1, 16'sh1388, 10'h12C, 10'h12C, 1'b1);
    report_and_stop;
  end
endmodule // tb_top
